// *** rtl/led_status_pkg.sv ***
package led_status_pkg;
	// Timing base
	localparam int SYS_CLK_NS = 100;
	localparam int UPDATE_PERIOD_US = 62500;
	localparam int UPDATE_CYCLES = UPDATE_PERIOD_US * 1000 / SYS_CLK_NS;
	localparam int SHIFT_CLK_NS = 800;
	localparam int SHIFT_HALF_CYCLES = SHIFT_CLK_NS / (2 * SYS_CLK_NS);
	localparam logic [1:0] DIV_LAST = 2'(SHIFT_HALF_CYCLES - 1);

	// Frame layout, index = shift position minus one
	localparam int FRAME_BITS = 48;
	localparam int DUMMY_BITS = 7;
	localparam int SW_BITS = 12;
	localparam int PORT_COUNT = 27;
	localparam int SW_FIRST_EARLY = 7;
	localparam int SW_FIRST_LATE = 34;
	localparam int PORT_FIRST_EARLY = 19;
	localparam int PORT_FIRST_LATE = 7;
	localparam int FLOW_POS = 46;
	localparam int FAULT_POS = 47;
	localparam logic [5:0] LAST_BIT_IDX = 6'(FRAME_BITS - 1);

	// Register map
	localparam int REG_ADDR_W = 4;
	localparam int REG_DATA_W = 8;
	localparam logic [3:0] CFG_LO_ADDR = 4'h0;
	localparam logic [3:0] CFG_HI_ADDR = 4'h1;
	localparam logic [3:0] STATUS_ADDR = 4'h2;
	localparam logic [3:0] FRAMES_ADDR = 4'h3;
	localparam logic [7:0] CFG_LO_RST = 8'h00;
	localparam logic [7:0] CFG_HI_RST = 8'h00;

	// Fields of the high configuration byte
	localparam int SW_HI_LSB = 0;
	localparam int SW_LAST_BIT = 4;
	localparam int TX_MCAST_BIT = 5;
	localparam int FORCE_FAULT_BIT = 6;
	localparam int FLOW_EN_BIT = 7;

	// Shifter states
	typedef enum logic [1:0] {
		SH_IDLE = 2'b01,
		SH_SHIFT = 2'b10
	} shift_state_e;
endpackage : led_status_pkg

// *** rtl/led_frame_if.sv ***
`timescale 1ns/1ps
// Frame hand-off between status collector and shifter
interface led_frame_if;
	logic [47:0] frame; // Bit 0 leaves first
	logic load; // One-cycle start pulse
	logic lamp; // Lamp test level
	logic busy; // Shifter is sending
	modport src (output frame, output load, output lamp, input busy);
	modport ser (input frame, input load, input lamp, output busy);
endinterface : led_frame_if

// *** rtl/led_frame_shifter.sv ***
`timescale 1ns/1ps
module led_frame_shifter (
	input wire logic sys_clk,
	input wire logic arst_n,
	led_frame_if.ser fif,
	output logic led_shift_clock,
	output logic led_serial_out
);
	// Whole shifter state
	typedef struct packed {
		led_status_pkg::shift_state_e st;
		logic [1:0] div; // Half-period divider
		logic [5:0] bit_idx; // Bit now on the line
		logic [47:0] shreg; // Remaining frame
		logic clk; // Shift clock flop
		logic data; // Serial data flop
	} shifter_s;

	shifter_s q;
	shifter_s n;
	logic wrap;

	assign wrap = (q.div == led_status_pkg::DIV_LAST);
	assign fif.busy = (q.st == led_status_pkg::SH_SHIFT);
	assign led_shift_clock = q.clk;
	assign led_serial_out = q.data;

	////////////////////////////////////////////////////////////////////////
	// Next state
	always_comb begin
		n = q;
		n.div = wrap ? 2'h0 : q.div + 2'h1;
		if (fif.lamp) begin
			n.st = led_status_pkg::SH_IDLE;
			n.data = 1'b1;
			if (wrap) begin
				n.clk = ~q.clk;
			end
		end else begin
			unique case (q.st)
				led_status_pkg::SH_IDLE: begin
					// Clock parks low; data holds last bit so a bare fault lamp stays lit
					n.clk = 1'b0;
					n.div = 2'h0;
					if (fif.load) begin
						n.st = led_status_pkg::SH_SHIFT;
						n.shreg = fif.frame;
						n.data = fif.frame[0];
						n.bit_idx = 6'h00;
					end
				end
				led_status_pkg::SH_SHIFT: begin
					if (wrap) begin
						if (!q.clk) begin
							n.clk = 1'b1;
						end else begin
							n.clk = 1'b0;
							if (q.bit_idx == led_status_pkg::LAST_BIT_IDX) begin
								n.st = led_status_pkg::SH_IDLE;
							end else begin
								n.bit_idx = q.bit_idx + 6'h01;
								n.shreg = q.shreg >> 1;
								n.data = q.shreg[1];
							end
						end
					end
				end
				default: begin
					// Illegal code recovers to idle
					n.st = led_status_pkg::SH_IDLE;
					n.clk = 1'b0;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// State register; data resets high as part of lamp test
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			q <= '{st: led_status_pkg::SH_IDLE, div: 2'h0, bit_idx: 6'h00,
				shreg: 48'h000000000000, clk: 1'b0, data: 1'b1};
		end else begin
			q <= n;
		end
	end
endmodule : led_frame_shifter

// *** rtl/led_status_serializer.sv ***
// Operation
// - port lamp off, on, or 8 Hz blink
// - send all status bits every sixteenth second
// - order bit picks software group before/after ports
// - 48 shift clocks, first seven bits zero
// - software bits at 8-19 or 35-46
// - sample software field once per frame
// - 27 port bits, port 00 first
// - port bit toggles after non-pause traffic
// - pause frames never count as activity
// - transmit multicast select gates activity
// - bit 47 shows enabled, recent flow control
// - fault bit is last, position 48
// - fault from integrity, parity or force bit
// - fault causes cleared by reset, load, start
// - lamp test during hardware reset
`timescale 1ns/1ps
module led_status_serializer #(
	parameter int TICK_CYCLES = led_status_pkg::UPDATE_CYCLES
) (
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic [26:0] port_link,
	input wire logic [26:0] port_frame_seen,
	input wire logic [26:0] port_frame_pause,
	input wire logic [26:0] port_frame_tx_mcast,
	input wire logic flow_ctrl_active,
	input wire logic config_crc_error,
	input wire logic mem_parity_error,
	input wire logic config_load_request,
	input wire logic start_request,
	input wire logic hw_soft_reset,
	output logic led_shift_clock,
	output logic led_serial_out
);
	localparam logic [23:0] TICK_LAST = 24'(TICK_CYCLES - 1);

	// Whole collector state
	typedef struct packed {
		logic [7:0] cfg_lo; // Software bits 7..0
		logic [7:0] cfg_hi; // Software bits 11..8 and controls
		logic [7:0] rdata; // Read data flop
		logic [23:0] tick_cnt; // Sixteenth-second timer
		logic [26:0] act; // Traffic seen this interval
		logic [26:0] phase; // Blink phase per port
		logic flow_seen; // Flow control seen this interval
		logic flow_bit; // Flow lamp value last frame
		logic crc_cause; // Integrity fault latched
		logic parity_cause; // Parity fault latched
		logic lamp; // Lamp test request
		logic load; // Frame start pulse
		logic [47:0] frame; // Frame handed to shifter
		logic [7:0] frames_sent; // Wrapping frame count
	} collector_s;

	collector_s q;
	collector_s n;
	logic tick;
	logic [11:0] sw_bits;
	logic [26:0] act_in;
	led_frame_if fif ();

	assign sw_bits = {q.cfg_hi[led_status_pkg::SW_HI_LSB +: 4], q.cfg_lo};
	assign tick = (q.tick_cnt == TICK_LAST);
	assign fif.frame = q.frame;
	assign fif.load = q.load;
	assign fif.lamp = q.lamp;
	assign reg_rdata = q.rdata;

	////////////////////////////////////////////////////////////////////////
	// Frame assembly, index 0 leaves first
	function automatic logic [47:0] build_frame(
		input logic [11:0] sw,
		input logic [26:0] ports,
		input logic flow,
		input logic fault,
		input logic sw_last
	);
		logic [47:0] f;
		f = 48'h000000000000;
		if (sw_last) begin
			f[led_status_pkg::PORT_FIRST_LATE +: led_status_pkg::PORT_COUNT] = ports;
			f[led_status_pkg::SW_FIRST_LATE +: led_status_pkg::SW_BITS] = sw;
		end else begin
			f[led_status_pkg::SW_FIRST_EARLY +: led_status_pkg::SW_BITS] = sw;
			f[led_status_pkg::PORT_FIRST_EARLY +: led_status_pkg::PORT_COUNT] = ports;
		end
		f[led_status_pkg::FLOW_POS] = flow;
		f[led_status_pkg::FAULT_POS] = fault;
		return f;
	endfunction : build_frame

	////////////////////////////////////////////////////////////////////////
	// Activity qualification
	always_comb begin
		act_in = port_frame_seen & ~port_frame_pause
			& (~port_frame_tx_mcast | {27{q.cfg_hi[led_status_pkg::TX_MCAST_BIT]}});
	end

	////////////////////////////////////////////////////////////////////////
	// Next state
	always_comb begin
		n = q;
		n.load = 1'b0;
		n.rdata = 8'h00;
		n.lamp = hw_soft_reset;
		n.tick_cnt = tick ? 24'h000000 : q.tick_cnt + 24'h000001;

		// interval close, events of this cycle count for the next
		if (tick) begin
			n.phase = ~(q.phase & q.act);
			n.act = act_in;
			// flow lamp needs enable and recent assertion
			n.flow_bit = q.cfg_hi[led_status_pkg::FLOW_EN_BIT] & q.flow_seen;
			n.flow_seen = flow_ctrl_active;
		end else begin
			n.act = q.act | act_in;
			n.flow_seen = q.flow_seen | flow_ctrl_active;
		end

		// cause clears, a new error in the same cycle wins
		if (config_crc_error) begin
			n.crc_cause = 1'b1;
		end else if (config_load_request || hw_soft_reset) begin
			n.crc_cause = 1'b0;
		end
		if (mem_parity_error) begin
			n.parity_cause = 1'b1;
		end else if (start_request || hw_soft_reset) begin
			n.parity_cause = 1'b0;
		end

		// Register writes, one byte each
		if (reg_wr) begin
			if (reg_addr == led_status_pkg::CFG_LO_ADDR) begin
				n.cfg_lo = reg_wdata;
			end else if (reg_addr == led_status_pkg::CFG_HI_ADDR) begin
				n.cfg_hi = reg_wdata;
			end
		end

		// Register reads, unmapped reads zero
		if (reg_rd) begin
			case (reg_addr)
				led_status_pkg::CFG_LO_ADDR: n.rdata = q.cfg_lo;
				led_status_pkg::CFG_HI_ADDR: n.rdata = q.cfg_hi;
				led_status_pkg::STATUS_ADDR: begin
					n.rdata = {3'h0, q.lamp, fif.busy, q.flow_bit, q.parity_cause,
						q.crc_cause};
				end
				led_status_pkg::FRAMES_ADDR: n.rdata = q.frames_sent;
				default: n.rdata = 8'h00;
			endcase
		end

		// register reset holds lamp test and restarts timing
		if (hw_soft_reset) begin
			n.cfg_lo = led_status_pkg::CFG_LO_RST;
			n.cfg_hi = led_status_pkg::CFG_HI_RST;
			n.tick_cnt = 24'h000000;
			n.act = 27'h0000000;
			n.phase = 27'h7FFFFFF;
			n.flow_seen = 1'b0;
			n.flow_bit = 1'b0;
		end else if (tick) begin
			// software field sampled here, once per frame
			n.frame = build_frame(sw_bits, port_link & n.phase, n.flow_bit,
				n.crc_cause | n.parity_cause | q.cfg_hi[led_status_pkg::FORCE_FAULT_BIT],
				q.cfg_hi[led_status_pkg::SW_LAST_BIT]);
			n.load = 1'b1;
			n.frames_sent = q.frames_sent + 8'h01;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// State register
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			q <= '{cfg_lo: led_status_pkg::CFG_LO_RST, cfg_hi: led_status_pkg::CFG_HI_RST,
				rdata: 8'h00, tick_cnt: 24'h000000, act: 27'h0000000,
				phase: 27'h7FFFFFF, flow_seen: 1'b0, flow_bit: 1'b0, crc_cause: 1'b0,
				parity_cause: 1'b0, lamp: 1'b0, load: 1'b0,
				frame: 48'h000000000000, frames_sent: 8'h00};
		end else begin
			q <= n;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Serial shifter; both pins come straight from its flops
	led_frame_shifter u_shifter (
		.sys_clk(sys_clk),
		.arst_n(arst_n),
		.fif(fif.ser),
		.led_shift_clock(led_shift_clock),
		.led_serial_out(led_serial_out)
	);

	////////////////////////////////////////////////////////////////////////
	// Checks
	// All of them stay quiet while the async reset is low
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!arst_n);

	// Cycles since last frame start
	logic [23:0] since_load;
	logic seen_load;
	// Rising shift clocks in the current frame
	logic [6:0] rise_cnt;
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			since_load <= 24'h000000;
			seen_load <= 1'b0;
			rise_cnt <= 7'h00;
		end else begin
			since_load <= q.load ? 24'h000000 : since_load + 24'h000001;
			// Lamp test restarts the timer, so the next period is not a full one
			seen_load <= q.lamp ? 1'b0 : (seen_load | q.load);
			if (q.load) begin
				rise_cnt <= 7'h00;
			end else if (led_shift_clock && !$past(led_shift_clock)) begin
				rise_cnt <= rise_cnt + 7'h01;
			end
		end
	end

	sequence frame_done_s;
		$fell(fif.busy) && !q.lamp;
	endsequence

	chk_frame_period: assert property (q.load && seen_load && !$past(q.lamp)
		|-> since_load == TICK_LAST) else $error("frame period wrong");
	chk_frame_clocks: assert property (frame_done_s |-> rise_cnt == 7'd48)
		else $error("frame did not have 48 clocks");
	chk_dummy_zero: assert property (q.load |-> q.frame[6:0] == 7'h00)
		else $error("dummy bits not zero");
	chk_sw_place: assert property (q.load |-> (q.frame[18:7] == $past(sw_bits)
		&& !$past(q.cfg_hi[led_status_pkg::SW_LAST_BIT]))
		|| (q.frame[45:34] == $past(sw_bits)
		&& $past(q.cfg_hi[led_status_pkg::SW_LAST_BIT])))
		else $error("software bits misplaced");
	// no link means dark, ports late
	chk_port_dark: assert property (q.load
		&& !$past(q.cfg_hi[led_status_pkg::SW_LAST_BIT])
		|-> (q.frame[45:19] & ~$past(port_link)) == 27'h0000000)
		else $error("port lit without link");
	// no link means dark, ports early
	chk_port_dark_early: assert property (q.load
		&& $past(q.cfg_hi[led_status_pkg::SW_LAST_BIT])
		|-> (q.frame[33:7] & ~$past(port_link)) == 27'h0000000)
		else $error("port lit without link, ports first");
	// flow lamp gated by enable as seen at the tick
	chk_flow_gate: assert property (q.load
		&& !$past(q.cfg_hi[led_status_pkg::FLOW_EN_BIT])
		|-> !q.frame[46]) else $error("flow lamp lit while disabled");
	chk_fault_force: assert property (q.load
		&& $past(q.cfg_hi[led_status_pkg::FORCE_FAULT_BIT])
		|-> q.frame[47]) else $error("forced fault missing");
	// fault bit is the OR of its causes
	chk_fault_src: assert property (q.load |-> q.frame[47] == (q.crc_cause
		| q.parity_cause | $past(q.cfg_hi[led_status_pkg::FORCE_FAULT_BIT])))
		else $error("fault bit disagrees with causes");
	chk_crc_clear: assert property (config_load_request && !config_crc_error
		|=> !q.crc_cause ##1 (!q.crc_cause || $past(config_crc_error)))
		else $error("integrity cause not cleared");
	chk_par_clear: assert property (start_request && !mem_parity_error
		|=> !q.parity_cause) else $error("parity cause not cleared");
	chk_lamp_data: assert property (hw_soft_reset [*3] |-> led_serial_out)
		else $error("lamp test data low");
	// lamp clock toggles every four cycles
	chk_lamp_clock: assert property (hw_soft_reset [*8]
		|-> led_shift_clock != $past(led_shift_clock, 4))
		else $error("lamp test clock stalled");
	chk_data_low_clk: assert property (!$stable(led_serial_out) && !$past(q.lamp)
		&& !q.lamp |-> !led_shift_clock) else $error("data moved with clock high");
	chk_idle_clk: assert property (!fif.busy && !q.lamp && !$past(q.lamp)
		|-> !led_shift_clock) else $error("shift clock moved between frames");
endmodule : led_status_serializer

// *** tb/led_shift_chain.sv ***
`timescale 1ns/1ps
// Six octal shift registers behind the LED pins
module led_shift_chain (
	input wire logic led_shift_clock,
	input wire logic led_serial_out,
	input wire logic clr,
	output logic [47:0] sr,
	output int cnt,
	output int glitch
);
	////////////////////////////////////////
	// Capture on rising clock, first bit ends in bit 0
	always @(posedge led_shift_clock or posedge clr) begin
		if (clr) begin
			cnt <= 0;
		end else begin
			sr <= {led_serial_out, sr[47:1]};
			cnt <= cnt + 1;
		end
	end
	// edges while high
	// A data edge while the clock is high risks a bad capture
	int gl = 0;
	assign glitch = gl;
	always @(led_serial_out) begin
		// Let a clock fall in the same step settle before looking
		#0;
		if (led_shift_clock === 1'b1) begin
			gl = gl + 1;
		end
	end
endmodule : led_shift_chain

// *** tb/tb_led_status_serializer.sv ***
`timescale 1ns/1ps
module tb_led_status_serializer;
	// Short interval keeps the run small
	localparam int TICK = 1000;
	logic sys_clk = 0;
	logic arst_n = 0;
	logic [3:0] reg_addr = 0;
	logic [7:0] reg_wdata = 0;
	logic reg_wr = 0;
	logic reg_rd = 0;
	logic [7:0] reg_rdata;
	logic [26:0] port_link = 0;
	logic [26:0] sn = 0;
	logic [26:0] ps = 0;
	logic [26:0] mc = 0;
	logic flow_ctrl_active = 0;
	logic [3:0] ev_q = 0; // Fault event pulses
	logic hw_soft_reset = 0;
	logic led_shift_clock;
	logic led_serial_out;
	logic clr = 0;
	logic [47:0] sr;
	int cnt;
	int glitch;
	int errors = 0;
	int comparisons = 0;
	int nframes = 0;
	int ev;
	logic [7:0] lo, hi, d;
	logic [26:0] ph, q, lk;
	logic crc_c, par_c, fl_old, fl_new, fl_exp;
	time last_t;

	////////////////////////////////////////
	always #50 sys_clk = ~sys_clk;

	led_status_serializer #(.TICK_CYCLES(TICK)) uut (.sys_clk(sys_clk), .arst_n(arst_n),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .port_link(port_link), .port_frame_seen(sn),
		.port_frame_pause(ps), .port_frame_tx_mcast(mc),
		.flow_ctrl_active(flow_ctrl_active), .config_crc_error(ev_q[0]),
		.mem_parity_error(ev_q[1]), .config_load_request(ev_q[2]),
		.start_request(ev_q[3]), .hw_soft_reset(hw_soft_reset),
		.led_shift_clock(led_shift_clock), .led_serial_out(led_serial_out));

	led_shift_chain chain (.led_shift_clock(led_shift_clock), .led_serial_out(led_serial_out),
		.clr(clr), .sr(sr), .cnt(cnt), .glitch(glitch));

	////////////////////////////////////////
	task chk(input logic [47:0] got, input logic [47:0] exp);
		comparisons++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task give_verdict;
		$display("errors=%0d comparisons=%0d", errors, comparisons);
		if (errors == 0 && comparisons > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : give_verdict

	task wr(input logic [3:0] a, input logic [7:0] v);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask : wr

	// Read data stand only in the cycle after the strobe
	task rd(input logic [3:0] a, output logic [7:0] v);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
	endtask : rd

	// Frame in shift order, bit 0 is position 1
	function logic [47:0] exp_frame(input logic [11:0] sw, input logic sl,
		input logic [26:0] p, input logic fl, input logic ft);
		logic [47:0] f;
		f = '0;
		if (!sl) begin
			f[18:7] = sw;
			f[45:19] = p;
		end else begin
			f[33:7] = p;
			f[45:34] = sw;
		end
		f[46] = fl;
		f[47] = ft;
		return f;
	endfunction : exp_frame

	// Waits for one whole frame and checks content, period when tcheck is set, and length
	task next_frame(input logic [47:0] e, input bit tcheck);
		int i;
		clr = 1'b1;
		#1 clr = 1'b0;
		i = 0;
		while (cnt != 48 && i < 3000) begin
			@(posedge sys_clk);
			#1 i++;
		end
		chk(sr, e);
		if (tcheck) begin
			chk(48'($time - last_t), 48'(TICK * 100));
		end
		last_t = $time;
		nframes++;
		repeat (60) @(posedge sys_clk);
		chk(48'(cnt), 48'd48);
	endtask : next_frame

	////////////////////////////////////////
	// Watchdog, far beyond the expected run
	initial begin
		#6000000;
		errors++;
		give_verdict();
	end

	// Main sequence
	initial begin
		void'($urandom(32'hD435));
		repeat (12) @(posedge sys_clk);
		chk(48'(led_serial_out), 48'h1);
		chk(48'(led_shift_clock), 48'h0);
		arst_n <= 1'b1;
		lo = 0;
		hi = 0;
		ph = '1;
		crc_c = 0;
		par_c = 0;
		fl_old = 0;
		// No link and no traffic sets every phase
		next_frame(48'h0, 0);
		for (int k = 0; k < 10; k++) begin
			d = 8'($urandom);
			// Single byte writes show the intermediate value
			if (k < 2 || $urandom % 2) begin
				hi = {d[7:5], k < 2 ? k[0] : d[4], d[3:0]};
				wr(4'h1, hi);
			end else begin
				lo = d;
				wr(4'h0, lo);
			end
			fl_new = 1'($urandom);
			flow_ctrl_active <= fl_new;
			fl_exp = hi[7] & (fl_old | fl_new);
			fl_old = fl_new;
			// First four passes set each fault event once
			ev = k < 4 ? k : $urandom % 5;
			@(posedge sys_clk);
			ev_q <= ev < 4 ? 4'h1 << ev : 4'h0;
			@(posedge sys_clk);
			ev_q <= 4'h0;
			crc_c = ev == 0 ? 1'b1 : ev == 2 ? 1'b0 : crc_c;
			par_c = ev == 1 ? 1'b1 : ev == 3 ? 1'b0 : par_c;
			lk = 27'($urandom);
			port_link <= lk;
			sn <= 27'($urandom);
			ps <= 27'($urandom);
			mc <= 27'($urandom);
			@(posedge sys_clk);
			q = sn & ~ps & (~mc | {27{hi[5]}});
			sn <= 0;
			// Phase toggles on traffic, else stays lit
			ph = ~(q & ph);
			next_frame(exp_frame({hi[3:0], lo}, hi[4], lk & ph, fl_exp, crc_c | par_c | hi[6]), 1);
			rd(4'h2, d);
			chk(48'(d), 48'({fl_exp, par_c, crc_c}));
			rd(4'h3, d);
			chk(48'(d), 48'(8'(nframes)));
		end
		// Read-only and unmapped places
		wr(4'h2, 8'hFF);
		rd(4'h2, d);
		chk(48'(d), 48'({fl_exp, par_c, crc_c}));
		rd(4'h7, d);
		chk(48'(d), 48'h0);
		// Lamp test under register reset, driven right after an edge
		@(posedge sys_clk);
		flow_ctrl_active <= 1'b0;
		port_link <= 0;
		hw_soft_reset <= 1'b1;
		repeat (4) @(posedge sys_clk);
		clr = 1'b1;
		#1 clr = 1'b0;
		repeat (40) begin
			@(posedge sys_clk);
			#1 chk(48'(led_serial_out), 48'h1);
		end
		chk(48'(cnt >= 4), 48'h1);
		rd(4'h2, d);
		chk(48'(d & 8'h13), 48'h10);
		@(posedge sys_clk);
		hw_soft_reset <= 1'b0;
		rd(4'h1, d);
		chk(48'(d), 48'h0);
		chk(48'(led_serial_out), 48'h1);
		next_frame(48'h0, 0);
		chk(48'(glitch), 48'h0);
		give_verdict();
	end
endmodule : tb_led_status_serializer
